//--- logic/avwf_formatter.sv
// Analog value word formatter: converter results to 16-bit words over APB
`timescale 1ns/1ps
module avwf_formatter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_start,
  input wire logic [avwf_pkg::AVWF_CH_W-1:0] conv_start_chan,
  input wire logic conv_valid,
  input wire logic [avwf_pkg::AVWF_CH_W-1:0] conv_chan,
  input wire logic signed [15:0] conv_raw,
  input wire logic conv_open,
  output logic [15:0] word_q,
  output logic [avwf_pkg::AVWF_CH_W-1:0] word_chan_q,
  output logic word_strobe_q,
  output logic irq
);
  import avwf_pkg::*;

  logic selective_q;
  logic [3:0] ctype_q [AVWF_NUM_CH];
  logic [AVWF_NUM_CH-1:0] active_q;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [15:0] word_d;
  logic [15:0] mem_rd_data;
  logic setup_ph;
  logic acc_wr;
  logic acc_rd;
  logic is_word;
  logic [AVWF_CH_W-1:0] word_idx;
  logic addr_ok;
  logic [7:0] sts_set;

  // Build one word from a raw converter count
  function automatic logic [15:0] fmt_word(input logic [3:0] ct, input logic [15:0] raw, input logic open_ckt);
    logic neg;
    logic [15:0] mag;
    logic ovf;
    logic brk;
    neg = raw[15];
    mag = neg ? 16'(~raw + 16'h0001) : raw;
    ovf = 1'b0;
    brk = 1'b0;
    if (ct == AVWF_CT_BIPOLAR)
    begin
      // Sign and magnitude, never two's complement
      ovf = (mag > AVWF_MAG_MAX);
    end
    else
    begin
      // Unipolar types: negative counts clamp to zero
      if (neg)
        mag = '0;
      neg = 1'b0;
      ovf = (mag > AVWF_MAG_MAX);
      // Only the resistance card reports an open circuit
      brk = (ct == AVWF_CT_RESIST) && open_ckt;
    end
    if (ovf)
      mag = AVWF_MAG_MAX;
    // Activity bit is zero once the conversion has finished
    return {neg, mag[11:0], 1'b0, brk, ovf};
  endfunction

  // Word address decode
  function automatic logic word_hit(input logic [7:0] a);
    return (a[7:4] == AVWF_OFF_WORD0[7:4]) && (a[1:0] == 2'h0);
  endfunction

  assign word_d = fmt_word(ctype_q[conv_chan], conv_raw, conv_open);
  assign setup_ph = psel && !penable;
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign is_word = word_hit(paddr);
  assign word_idx = paddr[2+AVWF_CH_W-1:2];
  assign addr_ok = is_word || (paddr == AVWF_OFF_CTRL) || (paddr == AVWF_OFF_CHTYPE)
    || (paddr == AVWF_OFF_STATUS) || (paddr == AVWF_OFF_MASK);

  // Never waits: word reads are fetched during the setup phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Stored words; the formatted result lands in one write
  avwf_word_mem #(
    .DEPTH(AVWF_NUM_CH),
    .AW(AVWF_CH_W),
    .DW(16)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(conv_valid),
    .wr_addr(conv_chan),
    .wr_data(word_d),
    .rd_en(setup_ph && !pwrite && is_word),
    .rd_addr(word_idx),
    .rd_data(mem_rd_data)
  );

  // Control register: scan mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      selective_q <= AVWF_RST_SELECTIVE;
    else if (acc_wr && paddr == AVWF_OFF_CTRL)
      selective_q <= pwdata[AVWF_CTRL_SEL_BIT];
  end

  // Channel type codes, one nibble per channel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < AVWF_NUM_CH; i++)
        ctype_q[i] <= AVWF_RST_CHTYPE[i*AVWF_TYPE_W +: AVWF_TYPE_W];
    end
    else if (acc_wr && paddr == AVWF_OFF_CHTYPE)
    begin
      for (int i = 0; i < AVWF_NUM_CH; i++)
        ctype_q[i] <= pwdata[i*AVWF_TYPE_W +: AVWF_TYPE_W];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= AVWF_RST_MASK;
    else if (acc_wr && paddr == AVWF_OFF_MASK)
      mask_q <= pwdata[7:0];
  end

  // Conversion in progress per channel; a new start wins over a finish
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_q <= '0;
    else
    begin
      for (int i = 0; i < AVWF_NUM_CH; i++)
      begin
        if (conv_start && conv_start_chan == AVWF_CH_W'(i))
          active_q[i] <= 1'b1;
        else if (conv_valid && conv_chan == AVWF_CH_W'(i))
          active_q[i] <= 1'b0;
      end
    end
  end

  // Event sources: new word, and new word with overflow
  always_comb
  begin
    sts_set = '0;
    if (conv_valid)
    begin
      sts_set[conv_chan] = 1'b1;
      sts_set[AVWF_STS_OVF_LSB + int'(conv_chan)] = word_d[AVWF_BIT_OVF];
    end
  end

  // Sticky status; a read clears, a same-cycle event still sets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= '0;
    else if (acc_rd && paddr == AVWF_OFF_STATUS)
      status_q <= sts_set;
    else
      status_q <= status_q | sts_set;
  end

  assign irq = |(status_q & mask_q);

  // Last formatted word for streaming consumers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_q <= '0;
      word_chan_q <= '0;
      word_strobe_q <= 1'b0;
    end
    else
    begin
      word_strobe_q <= conv_valid;
      if (conv_valid)
      begin
        word_q <= word_d;
        word_chan_q <= conv_chan;
      end
    end
  end

  // Read mux; activity is live, so a running selective conversion shows at once
  always_comb
  begin
    prdata = '0;
    if (acc_rd)
    begin
      if (is_word)
      begin
        prdata[15:0] = mem_rd_data;
        prdata[AVWF_BIT_ACT] = selective_q && active_q[word_idx];
      end
      else if (paddr == AVWF_OFF_CTRL)
        prdata[AVWF_CTRL_SEL_BIT] = selective_q;
      else if (paddr == AVWF_OFF_CHTYPE)
      begin
        for (int i = 0; i < AVWF_NUM_CH; i++)
          prdata[i*AVWF_TYPE_W +: AVWF_TYPE_W] = ctype_q[i];
      end
      else if (paddr == AVWF_OFF_STATUS)
        prdata[7:0] = status_q;
      else if (paddr == AVWF_OFF_MASK)
        prdata[7:0] = mask_q;
    end
  end

  // Checks on the formatted words
  a_cur_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_CURRENT && conv_raw > 16'sd4095
    |=> word_q[AVWF_BIT_OVF] && word_q[15:3] == 13'h0fff)
    else $error("current overflow not flagged or not saturated");

  a_cur_overrange: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_CURRENT && conv_raw > 16'sd2560 && conv_raw <= 16'sd4095
    |=> !word_q[AVWF_BIT_OVF] && word_q[15:3] == 13'($past(conv_raw)))
    else $error("current overrange word wrong");

  a_cur_below: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_CURRENT && conv_raw >= 16'sd0 && conv_raw < 16'sd512
    |=> !word_q[AVWF_BIT_OVF] && word_q[15:3] == 13'($past(conv_raw)))
    else $error("current underrange word wrong");

  a_cur_no_break: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_CURRENT |=> !word_q[AVWF_BIT_BRK])
    else $error("current channel flagged wire break");

  a_res_break: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_RESIST |=> word_q[AVWF_BIT_BRK] == $past(conv_open))
    else $error("resistance wire break not reported");

  a_res_range: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_RESIST && conv_raw >= 16'sd0
    |=> word_q[AVWF_BIT_OVF] == ($past(conv_raw) > 16'sd4095)
    && (word_q[AVWF_BIT_OVF] || word_q[15:3] == 13'($past(conv_raw))))
    else $error("resistance overflow or value wrong");

  a_bip_sign: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_BIPOLAR && conv_raw < 16'sd0 && conv_raw >= -16'sd4095
    |=> word_q[AVWF_BIT_SIGN] && !word_q[AVWF_BIT_OVF]
    && word_q[14:3] == 12'(-$past(conv_raw)))
    else $error("signed magnitude word wrong");

  a_word_update: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid |=> word_strobe_q && word_chan_q == $past(conv_chan) && !word_q[AVWF_BIT_ACT])
    else $error("word not updated as one unit");

  a_act_flag: assert property (@(posedge pclk) disable iff (!presetn)
    acc_rd && is_word && !selective_q |-> !prdata[AVWF_BIT_ACT])
    else $error("activity flag set during cyclic scan");

  // Range edges and saturation; these catch a wrong clamp that the middle values hide
  a_res_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_RESIST && conv_raw > 16'sd4095
    |=> word_q[AVWF_BIT_OVF] && word_q[15:3] == 13'h0fff)
    else $error("resistance overflow not flagged or not saturated");

  a_cur_nominal: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_CURRENT && conv_raw >= 16'sd512 && conv_raw <= 16'sd2560
    |=> !word_q[AVWF_BIT_OVF] && word_q[15:3] == 13'($past(conv_raw)))
    else $error("current nominal value not passed through");

  a_cur_negative: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_CURRENT && conv_raw < 16'sd0
    |=> !word_q[AVWF_BIT_OVF] && word_q[15:3] == 13'h0000)
    else $error("negative current count not clamped to zero");

  a_res_raw: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_RESIST && conv_raw >= 16'sd0 && conv_raw <= 16'sd4095
    |=> !word_q[AVWF_BIT_OVF] && word_q[15:3] == 13'($past(conv_raw)))
    else $error("resistance reading not passed raw");

  a_bip_positive: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_BIPOLAR && conv_raw >= 16'sd0 && conv_raw <= 16'sd4095
    |=> !word_q[AVWF_BIT_SIGN] && !word_q[AVWF_BIT_OVF]
    && word_q[14:3] == 12'($past(conv_raw)))
    else $error("positive signed magnitude word wrong");

  a_bip_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid && ctype_q[conv_chan] == AVWF_CT_BIPOLAR && (conv_raw > 16'sd4095 || conv_raw < -16'sd4095)
    |=> word_q[AVWF_BIT_OVF] && word_q[14:3] == 12'hfff
    && word_q[AVWF_BIT_SIGN] == ($past(conv_raw) < 16'sd0))
    else $error("signed magnitude overflow not saturated");

  // A read of status in the same cycle must not lose the new event
  a_status_event: assert property (@(posedge pclk) disable iff (!presetn)
    conv_valid |=> status_q[$past(conv_chan)])
    else $error("new word status bit not set");
endmodule // avwf_formatter

//--- logic/avwf_pkg.sv
// Constants shared by the analog value word formatter, its converter model and its bench
package avwf_pkg;
  localparam int AVWF_NUM_CH = 4;
  localparam int AVWF_CH_W = 2;
  // Register byte offsets
  localparam logic [7:0] AVWF_OFF_CTRL = 8'h00;
  localparam logic [7:0] AVWF_OFF_CHTYPE = 8'h04;
  localparam logic [7:0] AVWF_OFF_STATUS = 8'h08;
  localparam logic [7:0] AVWF_OFF_MASK = 8'h0c;
  localparam logic [7:0] AVWF_OFF_WORD0 = 8'h10;
  // Reset values
  localparam logic AVWF_RST_SELECTIVE = 1'b0;
  localparam logic [15:0] AVWF_RST_CHTYPE = 16'h3333;
  localparam logic [7:0] AVWF_RST_MASK = 8'h00;
  // Field positions
  localparam int AVWF_CTRL_SEL_BIT = 0;
  localparam int AVWF_TYPE_W = 4;
  localparam int AVWF_BIT_OVF = 0;
  localparam int AVWF_BIT_BRK = 1;
  localparam int AVWF_BIT_ACT = 2;
  localparam int AVWF_BIT_SIGN = 15;
  localparam int AVWF_STS_OVF_LSB = 4;
  // Channel type codes
  localparam logic [3:0] AVWF_CT_CURRENT = 4'h3;
  localparam logic [3:0] AVWF_CT_RESIST = 4'h4;
  localparam logic [3:0] AVWF_CT_BIPOLAR = 4'h5;
  // Magnitude limits in units
  localparam logic [15:0] AVWF_MAG_MAX = 16'h0fff;
  localparam logic [15:0] AVWF_CUR_LOW = 16'h0200;
  localparam logic [15:0] AVWF_CUR_HIGH = 16'h0a00;
endpackage

//--- logic/avwf_word_mem.sv
// Small store of measured-value words, one per channel, registered read
`timescale 1ns/1ps
module avwf_word_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2,
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem_q [DEPTH];

  // Whole word written in one cycle so fields never mix
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (wr_en)
      mem_q[wr_addr] <= wr_data;
  end

  // Read data from a flop; same-cycle write returns the old word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_data <= '0;
    else if (rd_en)
      rd_data <= mem_q[rd_addr];
  end
endmodule // avwf_word_mem

//--- tb/avwf_conv_model.sv
// Converter-side model that delivers start and result pulses to the formatter
`timescale 1ns/1ps
module avwf_conv_model (
  input wire logic pclk,
  output logic conv_start,
  output logic [avwf_pkg::AVWF_CH_W-1:0] conv_start_chan,
  output logic conv_valid,
  output logic [avwf_pkg::AVWF_CH_W-1:0] conv_chan,
  output logic signed [15:0] conv_raw,
  output logic conv_open
);
  import avwf_pkg::*;
  // Quiet outputs at time zero
  initial
  begin
    conv_start = 1'b0;
    conv_start_chan = '0;
    conv_valid = 1'b0;
    conv_chan = '0;
    conv_raw = 16'sh0;
    conv_open = 1'b0;
  end
  // One-cycle start pulse for a selective conversion
  task automatic start(input logic [AVWF_CH_W-1:0] ch);
    @(posedge pclk);
    conv_start <= 1'b1;
    conv_start_chan <= ch;
    @(posedge pclk);
    conv_start <= 1'b0;
  endtask
  // Result pulse; data scrambled after so stale values never look valid
  task automatic send(input logic [AVWF_CH_W-1:0] ch, input logic signed [15:0] raw, input logic op);
    @(posedge pclk);
    conv_valid <= 1'b1;
    conv_chan <= ch;
    conv_raw <= raw;
    conv_open <= op;
    @(posedge pclk);
    conv_valid <= 1'b0;
    conv_raw <= ~raw;
    conv_open <= ~op;
  endtask
endmodule // avwf_conv_model

//--- tb/analog_value_word_formatter_bench.sv
// Bench for the analog value word formatter: APB reads plus converter pulses
`timescale 1ns/1ps
module analog_value_word_formatter_bench;
  import avwf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se, conv_start, conv_valid, conv_open, word_strobe_q, irq;
  logic [AVWF_CH_W-1:0] conv_start_chan, conv_chan, word_chan_q;
  logic signed [15:0] conv_raw;
  logic [15:0] word_q, ew;
  int err_total = 0;
  int tests_run = 0;
  int chs[12] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2};
  int raws[12] = '{512, 2560, 3000, 5000, 300, 2049, 4096, 100, -1, 100, -4096, -32768};
  int ops[12] = '{0, 0, 0, 0, 1, 0, 0, 1, 0, 0, 0, 0};
  always #20 pclk = ~pclk;
  avwf_formatter avwf_formatter_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_start, .conv_start_chan, .conv_valid, .conv_chan, .conv_raw, .conv_open,
    .word_q, .word_chan_q, .word_strobe_q, .irq);
  avwf_conv_model avwf_conv_model_i (.pclk, .conv_start, .conv_start_chan, .conv_valid, .conv_chan,
    .conv_raw, .conv_open);
  // Verdict in one place, used by the main sequence and by timeouts
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  // Setup then access; pready polled under a bound, hung bus ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50)
    begin
      err_total++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Expected word built from the type, the raw units and the open-circuit input
  function automatic logic [15:0] fmt(input logic [3:0] t, input int raw, input logic op);
    logic s;
    int m;
    logic ov;
    s = (t == AVWF_CT_BIPOLAR) && (raw < 0);
    m = s ? -raw : ((raw < 0) ? 0 : raw);
    ov = m > 4095;
    if (ov)
      m = 4095;
    return {s, m[11:0], 1'b0, op && (t == AVWF_CT_RESIST), ov};
  endfunction
  function automatic logic [3:0] ty(input int ch);
    return (ch == 1) ? AVWF_CT_RESIST : ((ch == 2) ? AVWF_CT_BIPOLAR : AVWF_CT_CURRENT);
  endfunction
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AVWF_OFF_CHTYPE, 32'h0, rd, se);
    chk(rd, 32'h3333);
    apb(1'b0, 8'h40, 32'h0, rd, se);
    chk({rd[30:0], se}, 32'h1);
    apb(1'b1, AVWF_OFF_CHTYPE, 32'h3543, rd, se);
    $display("test reset_and_map done");
    for (int i = 0; i < 12; i++)
    begin
      ew = fmt(ty(chs[i]), raws[i], ops[i][0]);
      avwf_conv_model_i.send(chs[i][1:0], raws[i][15:0], ops[i][0]);
      #1;
      chk({word_strobe_q, word_chan_q, word_q}, {1'b1, chs[i][1:0], ew});
      apb(1'b0, AVWF_OFF_WORD0 + 8'(4 * chs[i]), 32'h0, rd, se);
      chk(rd, {16'h0, ew});
    end
    apb(1'b1, AVWF_OFF_WORD0, 32'hffff, rd, se);
    apb(1'b0, AVWF_OFF_WORD0, 32'h0, rd, se);
    chk(rd, {16'h0, fmt(AVWF_CT_CURRENT, 300, 1'b1)});
    $display("test formats done");
    apb(1'b1, AVWF_OFF_MASK, 32'h1, rd, se);
    #1 chk({31'h0, irq}, 32'h1);
    apb(1'b0, AVWF_OFF_STATUS, 32'h0, rd, se);
    chk(rd, 32'h77);
    @(posedge pclk);
    #1 chk({31'h0, irq}, 32'h0);
    avwf_conv_model_i.send(2'h1, 16'sd5, 1'b0);
    #1 chk({31'h0, irq}, 32'h0);
    avwf_conv_model_i.send(2'h0, -16'sd5, 1'b1);
    #1 chk({31'h0, irq}, 32'h1);
    apb(1'b0, AVWF_OFF_WORD0, 32'h0, rd, se);
    chk(rd, {16'h0, fmt(AVWF_CT_CURRENT, -5, 1'b1)});
    chk({31'h0, rd[14:3] < 12'd128}, 32'h1);
    $display("test interrupt done");
    apb(1'b1, AVWF_OFF_CTRL, 32'h1, rd, se);
    avwf_conv_model_i.start(2'h3);
    apb(1'b0, AVWF_OFF_WORD0 + 8'hc, 32'h0, rd, se);
    chk(rd, 32'h4);
    avwf_conv_model_i.send(2'h3, 16'sd600, 1'b0);
    apb(1'b0, AVWF_OFF_WORD0 + 8'hc, 32'h0, rd, se);
    chk(rd, {16'h0, fmt(AVWF_CT_CURRENT, 600, 1'b0)});
    chk(32'(rd[14:3]) - 32'd512, 32'd88);
    $display("test activity done");
    report_and_stop();
  end
endmodule // analog_value_word_formatter_bench
